// ===== design/ebh_pkg.sv
// Constants and types shared by the bus-hold handshake block
package ebh_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock period in ns; interface timing in interface clock periods
  localparam int CLK_PERIOD_NS = 5;
  localparam int SYNC_STAGES = 2;
  localparam int HZ_MIN_E = 4;
  localparam int LZ_MIN_E = 2;
  localparam int LZ_MAX_E = 7;
  localparam int ACK_MAX_E = 2;
  localparam int REQ_HOLD_MIN_E = 1;
  localparam int WAIT_W = 3;
  // Sync latency already counts toward the float delay
  localparam logic [WAIT_W-1:0] HZ_WAIT_CYC =
    WAIT_W'(HZ_MIN_E - SYNC_STAGES);

  ////////////////////////////////////////////////////////////////////////////
  // Delay from reset release to bus valid
  localparam int CNT_W = 16;
  localparam int BOOT_SLOW_PERIODS = 41115;
  localparam int BOOT_SLOW_NS = 21;
  localparam int BOOT_FAST_PERIODS = 148;
  localparam int BOOT_FAST_NS = 22;
  localparam logic [CNT_W-1:0] BOOT_SLOW_CYC = CNT_W'(BOOT_SLOW_PERIODS +
    (BOOT_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] BOOT_FAST_CYC = CNT_W'(BOOT_FAST_PERIODS +
    (BOOT_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0] STRAP_SETTLE_CYC = 2'(SYNC_STAGES);

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] GLOBAL_CONTROL_ONE_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] GLOBAL_CONTROL_TWO_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] HOLD_STATUS_ADDR = 8'h08;
  localparam int HOLD_DISABLE_BIT = 0;
  localparam int BUS_CLOCK_TRISTATE_BIT = 1;
  localparam logic HOLD_DISABLE_RST = 1'b0;
  localparam logic BUS_CLOCK_TRISTATE_RST = 1'b0;
  localparam int ST_GRANT_BIT = 0;
  localparam int ST_FLOAT_BIT = 1;
  localparam int ST_BOOT_DONE_BIT = 2;
  localparam int ST_STRAP_BIT = 3;
  localparam int ST_REQ_BIT = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Shared bus groups released during hold
  localparam int BUS_GROUPS = 7;
  localparam int GRP_CHIP_SELECT = 0;
  localparam int GRP_BYTE_ENABLE = 1;
  localparam int GRP_DATA = 2;
  localparam int GRP_ADDRESS = 3;
  localparam int GRP_STROBES = 4;
  localparam int GRP_SDRAM_CKE = 5;
  localparam int GRP_THIRD_OE = 6;

  typedef enum logic [2:0] {
    EBH_BOOT,
    EBH_OWN,
    EBH_WAIT,
    EBH_FLOAT,
    EBH_HELD,
    EBH_RECLAIM
  } ebh_state_e;

endpackage : ebh_pkg

// ===== design/ebh_sync.sv
// Two-stage level synchroniser for pin inputs
`timescale 1ns/100ps
module ebh_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic async_i,
  output logic sync_o
);
  import ebh_pkg::*;

  logic meta_q;
  logic sync_q;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule // ebh_sync

// ===== design/ebh_delay_cnt.sv
// Loadable down counter that flags when a delay has run out
`timescale 1ns/100ps
module ebh_delay_cnt (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic load_i,
  input wire logic [ebh_pkg::CNT_W-1:0] load_val_i,
  output logic done_o
);
  import ebh_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic armed_q;
  logic armed_d;

  always_comb begin
    cnt_d = cnt_q;
    armed_d = armed_q;
    if (load_i) begin
      cnt_d = load_val_i;
      armed_d = 1'b1;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= '0;
      armed_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      armed_q <= armed_d;
    end
  end

  assign done_o = armed_q && (cnt_q == '0);

endmodule // ebh_delay_cnt

// ===== design/ebh_hold_ctrl.sv
// Bus-hold handshake of the external memory interface
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps

// What this block does
// R01 - A hold request is granted only after every pending transfer ends.
// R02 - While the hold-disable bit is set the grant is withheld for good.
// R03 - The shared bus floats no sooner than four periods after the request.
// R04 - The grant goes low only after the bus floats, within two periods.
// R05 - The bus is driven again two to seven periods after release.
// R06 - The grant goes high only once the bus is driven, within two periods.
// R07 - The master holds its request low one period after seeing the grant.
// R08 - A bus clock whose tristate bit is clear keeps toggling during hold.
// R09 - A bus clock whose tristate bit is set floats with the bus in hold.
// R10 - The released set is selects, byte enables, data, address, strobes, SDRAM CKE and the third OE group.
// R11 - During chip reset all bus outputs, clock and grant are floated.
// R12 - After reset the bus turns valid after a strap-selected delay.
// R13 - The request is synchronised and decided on at transfer boundaries.
// R14 - The master drives the bus only while granted and frees it first.
module ebh_hold_ctrl #(
  parameter logic [ebh_pkg::CNT_W-1:0] BOOT_SLOW_CYC_P =
    ebh_pkg::BOOT_SLOW_CYC
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [ebh_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [ebh_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [ebh_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic hold_req_n_i,
  input wire logic clock_mode_strap_i,
  input wire logic xfer_busy_i,
  output logic bus_hold_grant_n_o,
  output logic bus_hold_grant_oe_n_o,
  output logic [ebh_pkg::BUS_GROUPS-1:0] bus_oe_n_o,
  output logic primary_bus_clock_out_o,
  output logic primary_bus_clock_oe_n_o,
  output logic second_bus_clock_out_o,
  output logic second_bus_clock_oe_n_o
);
  import ebh_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and boot delay
  logic req_n_sync;
  logic strap_sync;
  logic boot_done;
  logic boot_load;
  logic [CNT_W-1:0] boot_val;

  ebh_sync #(
    .RST_VAL(1'b1)
  ) u_req_sync (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .async_i(hold_req_n_i),
    .sync_o(req_n_sync)
  ); // see R13

  ebh_sync #(
    .RST_VAL(1'b0)
  ) u_strap_sync (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .async_i(clock_mode_strap_i),
    .sync_o(strap_sync)
  );

  ebh_delay_cnt u_boot_cnt (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .load_i(boot_load),
    .load_val_i(boot_val),
    .done_o(boot_done)
  );

  logic [1:0] settle_q;
  logic [1:0] settle_d;
  logic strap_q;
  logic strap_d;

  always_comb begin
    settle_d = settle_q;
    strap_d = strap_q;
    boot_load = 1'b0;
    // Strap read once its synchroniser holds the pin value
    if (settle_q != STRAP_SETTLE_CYC + 2'(1)) begin
      settle_d = settle_q + 2'(1);
      if (settle_q == STRAP_SETTLE_CYC) begin
        strap_d = strap_sync;
        boot_load = 1'b1;
      end
    end
  end

  // Strap value picks the boot delay
  assign boot_val = strap_d ? BOOT_FAST_CYC : BOOT_SLOW_CYC_P; // see R12

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      settle_q <= 2'h0;
      strap_q <= 1'b0;
    end else begin
      settle_q <= settle_d;
      strap_q <= strap_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  logic hold_disable_q;
  logic hold_disable_d;
  logic clk1_tri_q;
  logic clk1_tri_d;
  logic clk2_tri_q;
  logic clk2_tri_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic bus_float_q;
  logic grant_n_q;

  always_comb begin
    hold_disable_d = hold_disable_q;
    clk1_tri_d = clk1_tri_q;
    clk2_tri_d = clk2_tri_q;
    rdata_d = '0;
    if (reg_wr_i) begin
      if (reg_addr_i == GLOBAL_CONTROL_ONE_ADDR) begin
        hold_disable_d = reg_wdata_i[HOLD_DISABLE_BIT];
        clk1_tri_d = reg_wdata_i[BUS_CLOCK_TRISTATE_BIT];
      end else if (reg_addr_i == GLOBAL_CONTROL_TWO_ADDR) begin
        clk2_tri_d = reg_wdata_i[BUS_CLOCK_TRISTATE_BIT];
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == GLOBAL_CONTROL_ONE_ADDR) begin
        rdata_d[HOLD_DISABLE_BIT] = hold_disable_q;
        rdata_d[BUS_CLOCK_TRISTATE_BIT] = clk1_tri_q;
      end else if (reg_addr_i == GLOBAL_CONTROL_TWO_ADDR) begin
        rdata_d[BUS_CLOCK_TRISTATE_BIT] = clk2_tri_q;
      end else if (reg_addr_i == HOLD_STATUS_ADDR) begin
        rdata_d[ST_GRANT_BIT] = !grant_n_q;
        rdata_d[ST_FLOAT_BIT] = bus_float_q;
        rdata_d[ST_BOOT_DONE_BIT] = boot_done;
        rdata_d[ST_STRAP_BIT] = strap_q;
        rdata_d[ST_REQ_BIT] = !req_n_sync;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hold_disable_q <= HOLD_DISABLE_RST;
      clk1_tri_q <= BUS_CLOCK_TRISTATE_RST;
      clk2_tri_q <= BUS_CLOCK_TRISTATE_RST;
      rdata_q <= '0;
    end else begin
      hold_disable_q <= hold_disable_d;
      clk1_tri_q <= clk1_tri_d;
      clk2_tri_q <= clk2_tri_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Hold handshake state machine
  ebh_state_e state_q;
  ebh_state_e state_d;
  logic [WAIT_W-1:0] wait_q;
  logic [WAIT_W-1:0] wait_d;
  logic bus_float_d;
  logic grant_n_d;
  logic grant_oe_n_q;
  logic grant_oe_n_d;
  logic clk1_oe_n_q;
  logic clk1_oe_n_d;
  logic clk2_oe_n_q;
  logic clk2_oe_n_d;
  logic clk_div_q;
  logic clk_div_d;
  logic in_hold;

  always_comb begin
    state_d = state_q;
    wait_d = wait_q;
    case (state_q)
      EBH_BOOT: begin
        if (boot_done) begin
          state_d = EBH_OWN; // see R12
        end
      end
      EBH_OWN: begin
        if (!req_n_sync) begin
          state_d = EBH_WAIT;
          wait_d = HZ_WAIT_CYC; // see R03
        end
      end
      EBH_WAIT: begin
        if (req_n_sync) begin
          state_d = EBH_OWN;
        end else if (wait_q != '0) begin
          wait_d = wait_q - WAIT_W'(1);
        end else if (!xfer_busy_i && !hold_disable_q) begin
          state_d = EBH_FLOAT; // see R01 R02 R13
        end
      end
      EBH_FLOAT: begin
        state_d = EBH_HELD; // see R04
      end
      EBH_HELD: begin
        // Master keeps the request low past the grant edge
        if (req_n_sync) begin
          state_d = EBH_RECLAIM; // see R05 R07
        end
      end
      EBH_RECLAIM: begin
        state_d = EBH_OWN; // see R06
      end
      default: begin
        state_d = EBH_BOOT;
      end
    endcase
    in_hold = (state_d == EBH_FLOAT) || (state_d == EBH_HELD);
    bus_float_d = in_hold || (state_d == EBH_BOOT); // see R10 R11
    grant_n_d = !(state_d == EBH_HELD);
    grant_oe_n_d = (state_d == EBH_BOOT); // see R11
    clk1_oe_n_d = (state_d == EBH_BOOT) || (in_hold && clk1_tri_q);
    clk2_oe_n_d = (state_d == EBH_BOOT) || (in_hold && clk2_tri_q);
    clk_div_d = !clk_div_q; // see R08
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= EBH_BOOT;
      wait_q <= '0;
      bus_float_q <= 1'b1;
      grant_n_q <= 1'b1;
      grant_oe_n_q <= 1'b1;
      clk1_oe_n_q <= 1'b1;
      clk2_oe_n_q <= 1'b1;
      clk_div_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      bus_float_q <= bus_float_d;
      grant_n_q <= grant_n_d;
      grant_oe_n_q <= grant_oe_n_d;
      clk1_oe_n_q <= clk1_oe_n_d; // see R09
      clk2_oe_n_q <= clk2_oe_n_d; // see R09
      clk_div_q <= clk_div_d;
    end
  end

  // Every released group follows one enable
  for (genvar g = 0; g < BUS_GROUPS; g++) begin : g_bus_oe
    assign bus_oe_n_o[g] = bus_float_q; // see R10
  end

  assign bus_hold_grant_n_o = grant_n_q;
  assign bus_hold_grant_oe_n_o = grant_oe_n_q;
  assign primary_bus_clock_out_o = clk_div_q;
  assign primary_bus_clock_oe_n_o = clk1_oe_n_q;
  assign second_bus_clock_out_o = clk_div_q;
  assign second_bus_clock_oe_n_o = clk2_oe_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence drive_4_s;
    (!bus_float_q)[*4];
  endsequence

  sequence float_then_grant_s;
    bus_float_q && grant_n_q ##1 bus_float_q && !grant_n_q;
  endsequence

  pending_xfer_a: assert property ( // see R01
    $rose(bus_float_q) && boot_done |-> !$past(xfer_busy_i))
    else $error("bus floated while a transfer was pending");

  hold_disable_a: assert property ( // see R02
    hold_disable_q && state_q == EBH_WAIT |=> !bus_float_q)
    else $error("bus released while hold is disabled");

  float_delay_a: assert property ( // see R03
    $fell(req_n_sync) && state_q == EBH_OWN |-> drive_4_s)
    else $error("bus floated too early after hold request");

  grant_float_a: assert property ( // see R04
    $rose(bus_float_q) && state_q == EBH_FLOAT |-> float_then_grant_s)
    else $error("grant not given within two periods of float");

  grant_order_a: assert property ( // see R04
    $fell(grant_n_q) |-> bus_float_q && $past(bus_float_q))
    else $error("grant fell before the bus floated");

  reclaim_time_a: assert property ( // see R05
    $rose(req_n_sync) && state_q == EBH_HELD |=> !bus_float_q)
    else $error("bus not driven again in time after release");

  release_grant_a: assert property ( // see R06
    $fell(bus_float_q) && boot_done |-> ##[0:2] grant_n_q)
    else $error("grant not returned within two periods");

  grant_return_a: assert property ( // see R06
    $rose(grant_n_q) |-> !bus_float_q)
    else $error("grant returned before the bus was driven");

  clock_runs_a: assert property ( // see R08
    state_q == EBH_HELD && !clk1_tri_q && !clk2_tri_q |=>
      !primary_bus_clock_oe_n_o && !second_bus_clock_oe_n_o &&
      primary_bus_clock_out_o != $past(primary_bus_clock_out_o))
    else $error("bus clock stopped during hold");

  clock_float_a: assert property ( // see R09
    state_q == EBH_HELD && clk1_tri_q |-> primary_bus_clock_oe_n_o)
    else $error("primary bus clock driven during hold");

  boot_float_a: assert property ( // see R11 R12
    !boot_done |-> bus_float_q && grant_oe_n_q && clk1_oe_n_q)
    else $error("bus driven before the boot delay ran out");

endmodule // ebh_hold_ctrl

// ===== testbench/ebh_master_model.sv
// Model of the outside master that borrows the memory bus
`timescale 1ns/100ps
module ebh_master_model (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic want_i,
  input wire logic bus_hold_grant_n_i,
  output logic hold_req_n_o,
  output logic drive_o
);
  logic seen_q;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hold_req_n_o <= 1'b1;
      drive_o <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      seen_q <= !bus_hold_grant_n_i && !hold_req_n_o;
      drive_o <= want_i && !bus_hold_grant_n_i && !hold_req_n_o;
      if (want_i) begin
        hold_req_n_o <= 1'b0;
      end else if (!drive_o && (seen_q || bus_hold_grant_n_i)) begin
        hold_req_n_o <= 1'b1;
      end
    end
  end
endmodule // ebh_master_model

// ===== testbench/ebh_hold_ctrl_tb.sv
// Self-checking bench for the bus-hold handshake block
`timescale 1ns/100ps
module ebh_hold_ctrl_tb;
  import ebh_pkg::*;
  localparam logic [CNT_W-1:0] BOOT_P = 16'h0028;
  localparam logic [31:0] ALL_HZ = 32'h0000007f;
  logic ref_clk, reset_n, wr, rd, strap, busy, want, drive, req_n;
  logic grant_n, grant_oe_n, grant_pin, clk1, clk1_oe_n, clk2, clk2_oe_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, rd_val;
  logic [BUS_GROUPS-1:0] bus_oe_n;
  int fails = 0;
  int num_checks = 0;

  ebh_hold_ctrl #(.BOOT_SLOW_CYC_P(BOOT_P)) DUT (.ref_clk_i(ref_clk),
    .reset_n_i(reset_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .hold_req_n_i(req_n),
    .clock_mode_strap_i(strap), .xfer_busy_i(busy),
    .bus_hold_grant_n_o(grant_n), .bus_hold_grant_oe_n_o(grant_oe_n),
    .bus_oe_n_o(bus_oe_n), .primary_bus_clock_out_o(clk1),
    .primary_bus_clock_oe_n_o(clk1_oe_n), .second_bus_clock_out_o(clk2),
    .second_bus_clock_oe_n_o(clk2_oe_n));
  // Grant pin pulled high while floated
  assign grant_pin = grant_oe_n ? 1'b1 : grant_n;
  ebh_master_model u_master (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
    .want_i(want), .bus_hold_grant_n_i(grant_pin), .hold_req_n_o(req_n),
    .drive_o(drive));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s seen %h exp %h",
               $time, msg, seen, exp);
    end
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task automatic bus_read(input logic [ADDR_W-1:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    rd_val = rdata;
  endtask

  always @(negedge ref_clk) begin
    if (drive === 1'b1) check(32'(bus_oe_n), ALL_HZ, "contention");
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic req_start;
    int n;
    n = 0;
    @(posedge ref_clk);
    want <= 1'b1;
    do begin
      @(negedge ref_clk);
      n++;
    end while (req_n !== 1'b0 && n < 10);
  endtask

  task automatic grant_phase(input int min_n);
    int n;
    int m;
    n = 0;
    m = 0;
    while (bus_oe_n !== '1 && n < 200) begin
      check(32'(grant_n), 32'h1, "grant before float");
      @(negedge ref_clk);
      n++;
    end
    check(32'(n >= min_n), 32'h1, "float delay");
    check(32'(bus_oe_n), ALL_HZ, "released set");
    while (grant_n !== 1'b0 && m < 5) begin
      @(negedge ref_clk);
      m++;
    end
    check(32'(m <= 2), 32'h1, "grant delay");
  endtask

  task automatic release_phase(input logic tri_on);
    logic p1;
    logic p2;
    int n;
    int m;
    n = 0;
    m = 0;
    check(32'({clk1_oe_n, clk2_oe_n}), 32'({2{tri_on}}), "clk oe");
    repeat (3) begin
      p1 = clk1;
      p2 = clk2;
      @(negedge ref_clk);
      if (!tri_on) check(32'({clk1 ^ p1, clk2 ^ p2}), 32'h3, "clk");
    end
    @(posedge ref_clk);
    want <= 1'b0;
    while (req_n !== 1'b1 && m < 10) begin
      @(negedge ref_clk);
      m++;
    end
    while (bus_oe_n !== '0 && n < 20) begin
      check(32'(grant_n), 32'h0, "grant rose early");
      @(negedge ref_clk);
      n++;
    end
    check(32'(n >= 2 && n <= 7), 32'h1, "reclaim delay");
    check(32'({clk1_oe_n, clk2_oe_n}), 32'h0, "clk reclaim");
    m = 0;
    while (grant_n !== 1'b1 && m < 5) begin
      @(negedge ref_clk);
      m++;
    end
    check(32'(m <= 2), 32'h1, "grant release delay");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_boot(input logic s, input logic [CNT_W-1:0] exp);
    int n;
    n = 0;
    @(posedge ref_clk);
    reset_n <= 1'b0;
    strap <= s;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    check(32'(bus_oe_n), ALL_HZ, "bus in reset");
    check(32'({grant_oe_n, clk1_oe_n, clk2_oe_n}), 32'h7, "pins");
    @(posedge ref_clk);
    reset_n <= 1'b1;
    do begin
      @(negedge ref_clk);
      n++;
    end while (bus_oe_n !== '0 && n < 400);
    check(32'(n >= exp && n <= exp + 6), 32'h1, "boot");
    bus_read(HOLD_STATUS_ADDR);
    check(32'(rd_val[ST_BOOT_DONE_BIT]), 32'h1, "boot done flag");
    check(32'(rd_val[ST_STRAP_BIT]), 32'(s), "strap flag");
    $display("test reset_boot done");
  endtask

  task automatic t_regs;
    bus_write(GLOBAL_CONTROL_ONE_ADDR, 32'hffffffff);
    bus_write(GLOBAL_CONTROL_TWO_ADDR, 32'hffffffff);
    bus_read(GLOBAL_CONTROL_ONE_ADDR);
    check(rd_val, 32'h3, "control one");
    bus_read(GLOBAL_CONTROL_TWO_ADDR);
    check(rd_val, 32'h2, "control two");
    @(negedge ref_clk);
    check(rdata, 32'h0, "read data stands one cycle");
    bus_read(8'h40);
    check(rd_val, 32'h0, "unmapped read");
    bus_write(GLOBAL_CONTROL_ONE_ADDR, 32'h0);
    bus_write(GLOBAL_CONTROL_TWO_ADDR, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_hold_plain;
    logic [31:0] exp_st;
    exp_st = 32'h17 | (32'(strap) << ST_STRAP_BIT);
    req_start();
    grant_phase(HZ_MIN_E);
    bus_read(HOLD_STATUS_ADDR);
    check(rd_val, exp_st, "hold status");
    release_phase(1'b0);
    $display("test hold_plain done");
  endtask

  task automatic t_hold_busy;
    @(posedge ref_clk);
    busy <= 1'b1;
    req_start();
    repeat (20) @(negedge ref_clk);
    check(32'({grant_n, bus_oe_n}), 32'h80, "held by transfer");
    bus_read(HOLD_STATUS_ADDR);
    check(rd_val, 32'h14, "status while held off");
    @(posedge ref_clk);
    busy <= 1'b0;
    grant_phase(0);
    release_phase(1'b0);
    $display("test hold_busy done");
  endtask

  task automatic t_hold_disable;
    bus_write(GLOBAL_CONTROL_ONE_ADDR, 32'h1 << HOLD_DISABLE_BIT);
    req_start();
    repeat (40) @(negedge ref_clk);
    check(32'({grant_n, bus_oe_n}), 32'h80, "hold disabled");
    bus_write(GLOBAL_CONTROL_ONE_ADDR, 32'h0);
    grant_phase(0);
    release_phase(1'b0);
    $display("test hold_disable done");
  endtask

  task automatic t_clk_tri;
    bus_write(GLOBAL_CONTROL_ONE_ADDR, 32'h1 << BUS_CLOCK_TRISTATE_BIT);
    bus_write(GLOBAL_CONTROL_TWO_ADDR, 32'h1 << BUS_CLOCK_TRISTATE_BIT);
    req_start();
    grant_phase(HZ_MIN_E);
    release_phase(1'b1);
    bus_write(GLOBAL_CONTROL_ONE_ADDR, 32'h0);
    bus_write(GLOBAL_CONTROL_TWO_ADDR, 32'h0);
    $display("test clk_tri done");
  endtask

  initial begin
    reset_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = '0;
    strap = 1'b0;
    busy = 1'b0;
    want = 1'b0;
    t_reset_boot(1'b0, BOOT_P);
    t_regs();
    t_hold_plain();
    t_hold_busy();
    t_hold_disable();
    t_clk_tri();
    t_reset_boot(1'b1, BOOT_FAST_CYC);
    t_hold_plain();
    print_verdict();
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    print_verdict();
  end
endmodule // ebh_hold_ctrl_tb
